// *** rtl/pmc_mode_ctrl.sv ***
// Operation
// - pin status bits 6-3 show strap pins; address is 01, straps, half bit.
// - half-select bit at bit 2: 0 for channels 1-4, 1 for 5-8.
// - mode register: two bits per channel, reset zero; off/manual/semi/auto.
// - four-pair port with differing channel modes ignores power-on commands.
// - off mode: no power, no detection, no classification whatever the bits.
// - entering off clears event and fault bits of that channel.
// - entering off clears results, power status, enables, thresholds, foldback.
// - entering off sets two-pair and port four-pair policing to all ones.
// - entering off clears voltage, current and resistance measurements.
// - entering off clears assigned, previous class and autoclass measurements.
// - clearing may take up to 5 ms; busy shown meanwhile.
// - only the channel or port entering off is cleared.
// - power-good or power-enable falling by off entry sets its change event.
// - semi-auto to manual or off cancels a running cooldown.
// - manual mode makes no automatic change; idle until enable or power-on.
// - manual: setting detect or class enable runs exactly one cycle.
// - power-on command turns the channel on at once, no detect or class.
// - manual power-on gets no assigned class; software sets policing.
// - four-pair, one channel enabled: measure it alone, no connection check.
// - four-pair, both detect enables in one write: detect both, then check.
// - four-pair, both class enables in one write: staggered classification.
`timescale 1ns/100ps
`default_nettype none
module pmc_mode_ctrl #(
    parameter logic HALF_SELECT = 1'b0,
    parameter int CLEAR_CYCLES = pmc_pkg::CLEAR_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr_strap_pins,
    input wire logic [6:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_cmd,
    input wire logic [7:0] bus_wdata,
    input wire logic [1:0] four_pair_wired,
    input wire logic [3:0] power_good_status,
    input wire logic [3:0] power_enable_status,
    input wire logic [3:0] detect_done,
    input wire logic [3:0] detect_valid,
    input wire logic [3:0] class_done,
    output logic addr_hit,
    output logic [7:0] bus_rdata,
    output logic [7:0] chan_mode_field,
    output logic [3:0] detect_enable_bit,
    output logic [3:0] class_enable_bit,
    output logic [3:0] off_clear,
    output logic [1:0] port_off_clear,
    output logic [3:0] clear_busy,
    output logic [3:0] power_good_change,
    output logic [3:0] power_enable_change,
    output logic [3:0] cooldown_cancel,
    output logic [3:0] detect_start,
    output logic [3:0] class_start,
    output logic [3:0] power_on_start,
    output logic [1:0] conn_check_start
);
    // mode field of one channel
    function automatic pmc_pkg::pmc_mode_e mode_of(input logic [7:0] modes, input int ch);
        mode_of = pmc_pkg::pmc_mode_e'(modes[ch*pmc_pkg::MODE_W +: pmc_pkg::MODE_W]);
    endfunction

    // strap pin synchroniser
    logic [3:0] strap_meta;
    logic [3:0] strap_addr_bits;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strap_meta <= 4'h0;
            strap_addr_bits <= 4'h0;
        end else begin
            strap_meta <= addr_strap_pins;
            strap_addr_bits <= strap_meta;
        end
    end

    // address decode
    wire half_select_bit = HALF_SELECT;
    wire [6:0] own_addr = {pmc_pkg::ADDR_PREFIX, strap_addr_bits, half_select_bit};
    wire addr_ok = (bus_addr == own_addr) || (bus_addr == pmc_pkg::BCAST_ADDR);
    wire wr_ok = bus_wr && addr_ok;
    wire rd_ok = bus_rd && addr_ok;
    wire wr_mode = wr_ok && (bus_cmd == pmc_pkg::REG_OP_MODE);
    wire wr_en = wr_ok && (bus_cmd == pmc_pkg::REG_DET_CLS_EN);
    wire wr_power_on_cmd = wr_ok && (bus_cmd == pmc_pkg::REG_POWER_ON);

    // per channel decode
    logic [3:0] enter_off;
    logic [3:0] leave_semi;
    logic [3:0] is_manual;
    logic [3:0] is_off;
    logic [3:0] det_w;
    logic [3:0] cls_w;
    logic [3:0] power_on_cmd_w;
    logic [1:0] mode_mismatch;
    logic [1:0] port_enter_off;

    always_comb begin
        for (int i = 0; i < pmc_pkg::NCH; i++) begin
            enter_off[i] = wr_mode && mode_of(bus_wdata, i) == pmc_pkg::MODE_OFF
                && mode_of(chan_mode_field, i) != pmc_pkg::MODE_OFF;
            leave_semi[i] = wr_mode && mode_of(chan_mode_field, i) == pmc_pkg::MODE_SEMI
                && (mode_of(bus_wdata, i) == pmc_pkg::MODE_MANUAL
                || mode_of(bus_wdata, i) == pmc_pkg::MODE_OFF);
            is_manual[i] = mode_of(chan_mode_field, i) == pmc_pkg::MODE_MANUAL;
            is_off[i] = mode_of(chan_mode_field, i) == pmc_pkg::MODE_OFF;
            det_w[i] = wr_en && bus_wdata[pmc_pkg::DET_EN_LSB + i];
            cls_w[i] = wr_en && bus_wdata[pmc_pkg::CLS_EN_LSB + i];
            power_on_cmd_w[i] = wr_power_on_cmd && bus_wdata[pmc_pkg::POWER_ON_CMD_LSB + i];
        end
        for (int p = 0; p < pmc_pkg::NPORT; p++) begin
            mode_mismatch[p] = four_pair_wired[p]
                && mode_of(chan_mode_field, 2*p) != mode_of(chan_mode_field, 2*p+1);
            port_enter_off[p] = enter_off[2*p] || enter_off[2*p+1];
        end
    end

    // four-pair pairing of requests within one write
    logic [1:0] both_det;
    logic [1:0] both_cls;
    logic [1:0] cc_pend;
    logic [1:0] stagger_wait;
    logic [3:0] det_ok;
    logic [1:0] next_cc_pend;
    logic [1:0] next_stagger_wait;
    logic [3:0] next_det_ok;
    logic [1:0] next_conn_check;
    logic [3:0] next_class_start;
    logic [3:0] next_detect_start;
    logic [3:0] next_power_on;

    always_comb begin
        for (int p = 0; p < pmc_pkg::NPORT; p++) begin
            both_det[p] = four_pair_wired[p] && det_w[2*p] && det_w[2*p+1]
                && is_manual[2*p] && is_manual[2*p+1];
            both_cls[p] = four_pair_wired[p] && cls_w[2*p] && cls_w[2*p+1]
                && is_manual[2*p] && is_manual[2*p+1];
        end
        for (int i = 0; i < pmc_pkg::NCH; i++) begin
            next_detect_start[i] = det_w[i] && is_manual[i];
            // refused silently: off channel or four-pair port with mixed modes
            next_power_on[i] = power_on_cmd_w[i] && !is_off[i]
                && !mode_mismatch[i/2] && !enter_off[i];
            // a new detect request forgets the last result
            if (det_w[i] || enter_off[i]) begin
                next_det_ok[i] = 1'b0;
            end else if (detect_done[i]) begin
                next_det_ok[i] = detect_valid[i];
            end else begin
                next_det_ok[i] = det_ok[i];
            end
        end
        for (int p = 0; p < pmc_pkg::NPORT; p++) begin
            // second channel of a staggered pair starts after the first is done
            next_class_start[2*p] = cls_w[2*p] && is_manual[2*p];
            next_class_start[2*p+1] = (cls_w[2*p+1] && is_manual[2*p+1] && !both_cls[p])
                || (stagger_wait[p] && class_done[2*p] && is_manual[2*p+1]);
            next_conn_check[p] = cc_pend[p] && det_ok[2*p] && det_ok[2*p+1];
            // check waits for two valid detections, dropped on an invalid one
            if (port_enter_off[p] || both_det[p]) begin
                next_cc_pend[p] = both_det[p] && !port_enter_off[p];
            end else if (next_conn_check[p]) begin
                next_cc_pend[p] = 1'b0;
            end else if ((detect_done[2*p] && !detect_valid[2*p])
                || (detect_done[2*p+1] && !detect_valid[2*p+1])) begin
                next_cc_pend[p] = 1'b0;
            end else begin
                next_cc_pend[p] = cc_pend[p];
            end
            if (port_enter_off[p]) begin
                next_stagger_wait[p] = 1'b0;
            end else if (both_cls[p]) begin
                next_stagger_wait[p] = 1'b1;
            end else if (class_done[2*p]) begin
                next_stagger_wait[p] = 1'b0;
            end else begin
                next_stagger_wait[p] = stagger_wait[p];
            end
        end
    end

    // register file
    logic [7:0] det_cls_en;
    logic [7:0] next_det_cls_en;
    logic [7:0] next_rdata;

    always_comb begin
        next_det_cls_en = wr_en ? bus_wdata : det_cls_en;
        // off entry wins over enable bits of the same write
        for (int i = 0; i < pmc_pkg::NCH; i++) begin
            if (enter_off[i]) begin
                next_det_cls_en[pmc_pkg::DET_EN_LSB + i] = 1'b0;
                next_det_cls_en[pmc_pkg::CLS_EN_LSB + i] = 1'b0;
            end
        end
    end

    always_comb begin
        next_rdata = pmc_pkg::READ_IDLE;
        if (bus_cmd == pmc_pkg::REG_PIN_STATUS) begin
            next_rdata[pmc_pkg::PIN_STRAP_LSB +: 4] = strap_addr_bits;
            next_rdata[pmc_pkg::PIN_HALF_BIT] = half_select_bit;
        end else if (bus_cmd == pmc_pkg::REG_OP_MODE) begin
            next_rdata = chan_mode_field;
        end else if (bus_cmd == pmc_pkg::REG_DET_CLS_EN) begin
            next_rdata = det_cls_en;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chan_mode_field <= pmc_pkg::OP_MODE_RESET;
        end else if (wr_mode) begin
            chan_mode_field <= bus_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_rdata <= pmc_pkg::READ_IDLE;
        end else if (rd_ok) begin
            bus_rdata <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            det_cls_en <= pmc_pkg::DET_CLS_RESET;
            addr_hit <= 1'b0;
        end else begin
            det_cls_en <= next_det_cls_en;
            addr_hit <= addr_ok;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            detect_enable_bit <= 4'h0;
            class_enable_bit <= 4'h0;
        end else begin
            detect_enable_bit <= next_det_cls_en[pmc_pkg::DET_EN_LSB +: 4];
            class_enable_bit <= next_det_cls_en[pmc_pkg::CLS_EN_LSB +: 4];
        end
    end

    // off entry and cooldown cancel strobes to the owning register banks
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            off_clear <= 4'h0;
            port_off_clear <= 2'h0;
            power_good_change <= 4'h0;
            power_enable_change <= 4'h0;
            cooldown_cancel <= 4'h0;
        end else begin
            off_clear <= enter_off;
            port_off_clear <= port_enter_off;
            power_good_change <= enter_off & power_good_status;
            power_enable_change <= enter_off & power_enable_status;
            cooldown_cancel <= leave_semi;
        end
    end

    // manual sequencing strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            detect_start <= 4'h0;
            class_start <= 4'h0;
            power_on_start <= 4'h0;
            conn_check_start <= 2'h0;
        end else begin
            detect_start <= next_detect_start;
            class_start <= next_class_start;
            power_on_start <= next_power_on;
            conn_check_start <= next_conn_check;
        end
    end

    // pairing state of four-pair requests
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cc_pend <= 2'h0;
            stagger_wait <= 2'h0;
            det_ok <= 4'h0;
        end else begin
            cc_pend <= next_cc_pend;
            stagger_wait <= next_stagger_wait;
            det_ok <= next_det_ok;
        end
    end

    // clearing window per channel
    for (genvar g = 0; g < pmc_pkg::NCH; g++) begin : g_clear
        pmc_clear_timer #(
            .CYCLES(CLEAR_CYCLES)
        ) u_timer (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .start(enter_off[g]),
            .busy(clear_busy[g])
        );
    end
endmodule
`default_nettype wire

// *** common/pmc_pkg.sv ***
`default_nettype none
package pmc_pkg;
    // channels served by one logical slave, ports of two channels each
    localparam int NCH = 4;
    localparam int NPORT = 2;

    // register commands
    localparam logic [7:0] REG_PIN_STATUS = 8'h11;
    localparam logic [7:0] REG_OP_MODE = 8'h12;
    localparam logic [7:0] REG_DET_CLS_EN = 8'h14;
    localparam logic [7:0] REG_POWER_ON = 8'h19;

    // reset values
    localparam logic [7:0] OP_MODE_RESET = 8'h00;
    localparam logic [7:0] DET_CLS_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // field positions
    localparam int PIN_STRAP_LSB = 3;
    localparam int PIN_HALF_BIT = 2;
    localparam int DET_EN_LSB = 0;
    localparam int CLS_EN_LSB = 4;
    localparam int POWER_ON_CMD_LSB = 0;
    localparam int MODE_W = 2;

    // bus address layout
    localparam logic [1:0] ADDR_PREFIX = 2'h1;
    localparam logic [6:0] BCAST_ADDR = 7'h7F;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_MANUAL = 2'b01,
        MODE_SEMI = 2'b10,
        MODE_AUTO = 2'b11
    } pmc_mode_e;

    // register clearing window after entry into off mode
    localparam int CLEAR_TIME_US = 5000;
    localparam int CLK_MHZ = 10;
    localparam int CLEAR_CYCLES = CLEAR_TIME_US * CLK_MHZ;
    localparam int CLEAR_CNT_W = 16;
endpackage
`default_nettype wire

// *** rtl/pmc_clear_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_clear_timer #(
    parameter int CYCLES = pmc_pkg::CLEAR_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy
);
    localparam logic [pmc_pkg::CLEAR_CNT_W-1:0] LAST =
        pmc_pkg::CLEAR_CNT_W'(CYCLES - 1);
    localparam logic [pmc_pkg::CLEAR_CNT_W-1:0] ZERO = '0;
    localparam logic [pmc_pkg::CLEAR_CNT_W-1:0] ONE = 16'h0001;

    logic [pmc_pkg::CLEAR_CNT_W-1:0] count;
    logic [pmc_pkg::CLEAR_CNT_W-1:0] next_count;
    logic next_busy;

    // restart on a new entry while still busy
    assign next_busy = start ? 1'b1 : (busy && count != LAST);
    assign next_count = start ? ZERO : (busy ? count + ONE : ZERO);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            count <= ZERO;
        end else begin
            busy <= next_busy;
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// *** bench/pmc_mode_ctrl_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_mode_ctrl_sva #(
    parameter logic HALF_SELECT = 1'b0,
    parameter int CLEAR_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr_strap_pins,
    input wire logic [6:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_cmd,
    input wire logic [7:0] bus_wdata,
    input wire logic [3:0] power_good_status,
    input wire logic [3:0] power_enable_status,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] chan_mode_field,
    input wire logic [3:0] off_clear,
    input wire logic [3:0] clear_busy,
    input wire logic [3:0] power_good_change,
    input wire logic [3:0] power_enable_change,
    input wire logic [3:0] cooldown_cancel,
    input wire logic [3:0] power_on_start,
    input wire logic [1:0] conn_check_start
);
    wire logic hit = bus_addr == {pmc_pkg::ADDR_PREFIX, addr_strap_pins, HALF_SELECT}
        || bus_addr == pmc_pkg::BCAST_ADDR;
    wire logic mode_wr = bus_wr && hit && bus_cmd == pmc_pkg::REG_OP_MODE;
    wire logic pin_rd = bus_rd && hit && bus_cmd == pmc_pkg::REG_PIN_STATUS;
    logic [3:0] is_off, into_off;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            is_off[i] = chan_mode_field[2*i +: 2] == 2'b00;
            into_off[i] = mode_wr && bus_wdata[2*i +: 2] == 2'b00 && !is_off[i];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_PIN_READ: assert property (pin_rd |=>
        bus_rdata == {1'b0, $past(addr_strap_pins), HALF_SELECT, 2'b00})
        else $error("pin status read wrong");
    AST_MISS_HOLD: assert property (bus_rd && !hit |=> $stable(bus_rdata))
        else $error("foreign read changed read data");
    AST_MODE_WR: assert property (mode_wr |=> chan_mode_field == $past(bus_wdata))
        else $error("mode register not loaded");
    AST_MODE_HOLD: assert property (!mode_wr |=> $stable(chan_mode_field))
        else $error("mode register changed without write");
    AST_OFF_CLEAR: assert property (##1 off_clear == $past(into_off))
        else $error("off entry strobe wrong");
    AST_PG_CHANGE: assert property (
        ##1 power_good_change == ($past(into_off) & $past(power_good_status)))
        else $error("power good change wrong");
    AST_PE_CHANGE: assert property (
        ##1 power_enable_change == ($past(into_off) & $past(power_enable_status)))
        else $error("power enable change wrong");
    AST_BUSY: assert property (off_clear[0] |-> clear_busy[0] [*8])
        else $error("clear busy dropped early");
    AST_OFF_NO_POWER_ON_CMD: assert property (##1 (power_on_start & $past(is_off)) == 4'h0)
        else $error("off channel powered");
    cover property (off_clear != 4'h0);
    cover property (conn_check_start != 2'h0);
    cover property (cooldown_cancel != 4'h0);
endmodule
bind pmc_mode_ctrl pmc_mode_ctrl_sva #(.HALF_SELECT(HALF_SELECT), .CLEAR_CYCLES(CLEAR_CYCLES)) i_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr_strap_pins(addr_strap_pins),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_cmd(bus_cmd),
    .bus_wdata(bus_wdata), .power_good_status(power_good_status),
    .power_enable_status(power_enable_status), .bus_rdata(bus_rdata),
    .chan_mode_field(chan_mode_field), .off_clear(off_clear), .clear_busy(clear_busy),
    .power_good_change(power_good_change), .power_enable_change(power_enable_change),
    .cooldown_cancel(cooldown_cancel), .power_on_start(power_on_start),
    .conn_check_start(conn_check_start));
`default_nettype wire

// *** bench/pmc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_host_model (
    input wire logic ref_clk,
    output var logic [6:0] bus_addr,
    output var logic bus_wr,
    output var logic bus_rd,
    output var logic [7:0] bus_cmd,
    output var logic [7:0] bus_wdata
);
    initial begin
        {bus_addr, bus_cmd, bus_wdata, bus_rd, bus_wr} = 25'h0;
    end
    // one byte per access; address, command and data lines show the inverse once released, strobes go low
    task automatic acc(input logic rd, input logic [6:0] a, input logic [7:0] c,
        input logic [7:0] d);
        @(negedge ref_clk);
        {bus_addr, bus_cmd, bus_wdata, bus_rd, bus_wr} = {a, c, d, rd, !rd};
        @(negedge ref_clk);
        {bus_addr, bus_cmd, bus_wdata, bus_rd, bus_wr} = {~a, ~c, ~d, 2'b00};
    endtask
endmodule
`default_nettype wire

// *** bench/pse_channel_mode_control_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("wrong value %s expected %h seen %h", nm, (e), (g)); \
    end \
end
module pse_channel_mode_control_test;
    localparam int CLR = 20;
    int seed = 57816;
    int mismatches = 0;
    int n_compared = 0;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_seen = 1'b0;
    logic [3:0] straps = 4'h0, pg = 4'h0, pe = 4'h0, dd = 4'h0, dv = 4'h0, cd = 4'h0;
    logic [1:0] fpw = 2'h0;
    logic [1:0] seen;
    logic [6:0] own;
    logic [7:0] e;
    logic [7:0] exp_q[$];
    logic [6:0] bus_addr;
    logic [7:0] bus_cmd, bus_wdata, bus_rdata, mode;
    logic bus_wr, bus_rd, addr_hit;
    logic [3:0] det_en, cls_en, offc, busy, pgc, pec, cool, det_st, cls_st, power_on_cmd;
    logic [1:0] port_off, conn;
    always #50 ref_clk = ~ref_clk;
    pmc_host_model i_host (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_cmd(bus_cmd), .bus_wdata(bus_wdata));
    pmc_mode_ctrl #(.HALF_SELECT(1'b0), .CLEAR_CYCLES(CLR)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr_strap_pins(straps), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_cmd(bus_cmd), .bus_wdata(bus_wdata),
        .four_pair_wired(fpw), .power_good_status(pg), .power_enable_status(pe),
        .detect_done(dd), .detect_valid(dv), .class_done(cd), .addr_hit(addr_hit),
        .bus_rdata(bus_rdata), .chan_mode_field(mode), .detect_enable_bit(det_en),
        .class_enable_bit(cls_en), .off_clear(offc), .port_off_clear(port_off),
        .clear_busy(busy), .power_good_change(pgc), .power_enable_change(pec),
        .cooldown_cancel(cool), .detect_start(det_st), .class_start(cls_st),
        .power_on_start(power_on_cmd), .conn_check_start(conn));
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        i_host.acc(1'b0, own, c, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] x);
        exp_q.push_back(x);
        i_host.acc(1'b1, a, c, 8'h00);
    endtask
    task automatic pulse(input logic [3:0] d, input logic [3:0] c);
        @(negedge ref_clk);
        {dd, dv, cd} = {d, d, c};
        @(negedge ref_clk);
        {dd, dv, cd} = {4'h0, ~d, 4'h0};
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge ref_clk) rd_seen <= bus_rd;
    always @(negedge ref_clk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("read data", e, bus_rdata)
        end
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end
    initial begin
        straps = 4'($random(seed));
        own = {2'b01, straps, 1'b0};
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        `CHK("mode reset", 8'h00, mode)
        // strap pins need two edges through the synchroniser
        repeat (2) @(negedge ref_clk);
        rd(own, 8'h11, {1'b0, straps, 3'b000});
        for (int m = 0; m < 4; m++) begin
            wr(8'h12, {4{2'(m)}});
            `CHK("mode", {4{2'(m)}}, mode)
        end
        rd(7'h7F, 8'h12, 8'hFF);
        `CHK("addr hit", 1'b1, addr_hit)
        rd(~own, 8'h12, 8'hFF);
        `CHK("addr miss", 1'b0, addr_hit)
        rd(own, 8'h13, 8'h00);
        {pg, pe} = 8'hF6;
        wr(8'h12, 8'h55);
        wr(8'h14, 8'h23);
        `CHK("det start", 4'h3, det_st)
        wr(8'h12, 8'h51);
        `CHK("off clear", 4'h2, offc)
        `CHK("port clear", 2'h1, port_off)
        `CHK("pg change", 4'h2, pgc)
        `CHK("pe change", 4'h2, pec)
        `CHK("enables", 8'h01, {cls_en, det_en})
        `CHK("busy", 4'h2, busy)
        repeat (CLR - 1) @(negedge ref_clk);
        `CHK("busy hold", 4'h2, busy)
        @(negedge ref_clk);
        `CHK("busy end", 4'h0, busy)
        wr(8'h12, 8'hAA);
        wr(8'h12, 8'hA9);
        `CHK("cancel", 4'h1, cool)
        wr(8'h12, 8'h28);
        `CHK("cancel off", 4'h8, cool)
        `CHK("clear two", 4'h9, offc)
        `CHK("pg two", 4'h9, pgc)
        fpw = 2'h3;
        wr(8'h12, 8'h55);
        wr(8'h19, 8'h0F);
        `CHK("power on", 4'hF, power_on_cmd)
        wr(8'h12, 8'h54);
        wr(8'h19, 8'h0F);
        `CHK("power refused", 4'hC, power_on_cmd)
        wr(8'h12, 8'h55);
        wr(8'h14, 8'h03);
        `CHK("det both", 4'h3, det_st)
        pulse(4'h3, 4'h0);
        for (int k = 0; k < 6 && conn === 2'h0; k++) @(negedge ref_clk);
        `CHK("conn check", 2'h1, conn)
        wr(8'h14, 8'h04);
        `CHK("det solo", 4'h4, det_st)
        pulse(4'h4, 4'h0);
        seen = 2'h0;
        repeat (6) begin
            seen = seen | conn;
            @(negedge ref_clk);
        end
        `CHK("no conn check", 2'h0, seen)
        wr(8'h14, 8'h30);
        `CHK("cls first", 4'h1, cls_st)
        pulse(4'h0, 4'h1);
        for (int k = 0; k < 6 && cls_st === 4'h0; k++) @(negedge ref_clk);
        `CHK("cls second", 4'h2, cls_st)
        finish_test();
    end
endmodule
`default_nettype wire
